// file: inc/frame_timing_pkg.sv
package frame_timing_pkg;
  // Master counter geometry: one 125 us frame of master clock cycles
  localparam int          CNT_W            = 11;
  localparam int          FRAME_CYCLES     = 2048;
  localparam logic [10:0] CNT_LAST         = 11'h7ff;
  localparam logic [10:0] CNT_ZERO         = 11'h000;
  localparam logic [10:0] CNT_STEP         = 11'h001;
  // Data-memory pulse toggles this many cycles after the counter origin
  localparam int          DFP_TOGGLE_DELAY = 64;
  localparam logic [10:0] DFP_TOGGLE_CNT   = 11'(DFP_TOGGLE_DELAY - 1);
  // Regenerated frame pulse spans counts 2046..2047,0..1 (one 4 MHz period)
  localparam logic [10:0] FP_START_CNT     = 11'h7fe;
  localparam logic [10:0] FP_END_CNT       = 11'h001;
  // Counter bit that forms the derived 4 MHz clock
  localparam int          C4_PHASE_BIT     = 1;
  // Reset values of the outputs
  localparam logic        DFP_RST          = 1'b0;
  localparam logic        FP_N_RST         = 1'b1;
  localparam logic        C4_RST           = 1'b0;
endpackage

// file: src/fall_detect.sv
`timescale 1ns/1ps
// Registers a level and flags its high-to-low transition
module fall_detect (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_level,
  output logic      o_fall
);
  logic prev_r;
  logic prev_nxt;

  always_comb begin
    prev_nxt = i_level;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign o_fall = prev_r & ~i_level;
endmodule

// file: src/frame_timing_generator.sv
`timescale 1ns/1ps
// Overview of operation
// - Frame boundary is first 4 MHz clock fall after incoming frame pulse falls.
// - Data-memory pulse toggles 64 cycles after boundary, 65 with clock delay.
// - Data-memory pulse changes state once per frame, giving 4 kHz.
// - Two data-memory pulse outputs, always complementary, switching together.
// - Regenerated active-low 8 kHz frame pulse, retimed to the master clock.
// - Regenerated frame pulse edges align with derived 4 MHz clock edges.
// - Counter resets at boundary, or one master cycle later with clock delay.
// - Derived 4 MHz clock falls in the middle of regenerated frame pulse.
module frame_timing_generator (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_sync_clock_4m_in,
  input  wire logic i_system_frame_pulse_in_n,
  input  wire logic i_clock_delay_select,
  output logic      o_data_memory_frame_pulse,
  output logic      o_data_memory_frame_pulse_n,
  output logic      o_regenerated_frame_pulse_out_n,
  output logic      o_derived_clock_4m_out
);
  logic                                  c4_fall;
  logic                                  fp_fall;
  logic                                  boundary;
  logic                                  reset_req;
  logic                                  realign;
  logic                                  pend_r;
  logic                                  pend_nxt;
  logic                                  bnd_d1_r;
  logic                                  bnd_d1_nxt;
  logic [frame_timing_pkg::CNT_W-1:0]    cnt_r;
  logic [frame_timing_pkg::CNT_W-1:0]    cnt_nxt;
  logic                                  dfp_r;
  logic                                  dfp_nxt;
  logic                                  dfp_n_r;
  logic                                  dfp_n_nxt;
  logic                                  fp_n_r;
  logic                                  fp_n_nxt;
  logic                                  c4_r;
  logic                                  c4_nxt;

  fall_detect u_c4_fall (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_sync_clock_4m_in),
    .o_fall    (c4_fall)
  );

  fall_detect u_fp_fall (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_system_frame_pulse_in_n),
    .o_fall    (fp_fall)
  );

  // Boundary detection: arm on frame pulse fall, fire on next 4 MHz fall
  always_comb begin
    boundary   = c4_fall & pend_r;
    pend_nxt   = pend_r;
    if (boundary) begin
      pend_nxt = 1'b0;
    end
    if (fp_fall) begin
      pend_nxt = 1'b1;
    end
    bnd_d1_nxt = boundary;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_r   <= 1'b0;
      bnd_d1_r <= 1'b0;
    end else begin
      pend_r   <= pend_nxt;
      bnd_d1_r <= bnd_d1_nxt;
    end
  end

  // Master counter, realigned at every boundary
  always_comb begin
    reset_req = i_clock_delay_select ? bnd_d1_r : boundary;
    realign   = reset_req && (cnt_r != frame_timing_pkg::CNT_LAST);
    if (reset_req) begin
      cnt_nxt = frame_timing_pkg::CNT_ZERO;
    end else begin
      cnt_nxt = cnt_r + frame_timing_pkg::CNT_STEP;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r <= frame_timing_pkg::CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Output decode from the counter, registered
  always_comb begin
    dfp_nxt = dfp_r;
    if (cnt_r == frame_timing_pkg::DFP_TOGGLE_CNT) begin
      dfp_nxt = ~dfp_r;
    end
    dfp_n_nxt = ~dfp_nxt;
    fp_n_nxt  = ~((cnt_nxt >= frame_timing_pkg::FP_START_CNT) ||
                  (cnt_nxt <= frame_timing_pkg::FP_END_CNT));
    c4_nxt    = cnt_nxt[frame_timing_pkg::C4_PHASE_BIT];
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dfp_r   <= frame_timing_pkg::DFP_RST;
      dfp_n_r <= ~frame_timing_pkg::DFP_RST;
      fp_n_r  <= frame_timing_pkg::FP_N_RST;
      c4_r    <= frame_timing_pkg::C4_RST;
    end else begin
      dfp_r   <= dfp_nxt;
      dfp_n_r <= dfp_n_nxt;
      fp_n_r  <= fp_n_nxt;
      c4_r    <= c4_nxt;
    end
  end

  assign o_data_memory_frame_pulse       = dfp_r;
  assign o_data_memory_frame_pulse_n     = dfp_n_r;
  assign o_regenerated_frame_pulse_out_n = fp_n_r;
  assign o_derived_clock_4m_out          = c4_r;

  AST_BOUNDARY_CAUSE: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    boundary |-> (c4_fall && $past(pend_r || fp_fall)))
    else $error("Boundary without armed frame pulse");

  AST_DFP_DELAY_0: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (boundary && !i_clock_delay_select) ##1 !i_clock_delay_select
    |-> ##64 (o_data_memory_frame_pulse != $past(o_data_memory_frame_pulse)))
    else $error("Data-memory pulse not toggled 64 cycles after boundary");

  AST_DFP_DELAY_1: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (boundary && i_clock_delay_select) ##1 i_clock_delay_select
    |-> ##65 (o_data_memory_frame_pulse != $past(o_data_memory_frame_pulse)))
    else $error("Data-memory pulse not toggled 65 cycles after boundary");

  AST_DFP_ONCE: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (o_data_memory_frame_pulse != $past(o_data_memory_frame_pulse))
    |-> ($past(cnt_r) == frame_timing_pkg::DFP_TOGGLE_CNT))
    else $error("Data-memory pulse toggled at wrong count");

  AST_DFP_PAIR: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    o_data_memory_frame_pulse != o_data_memory_frame_pulse_n)
    else $error("Data-memory pulse pair not complementary");

  AST_FP_START: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    ($fell(o_regenerated_frame_pulse_out_n) && !$past(realign) && !$past(i_sys_rst, 2))
    |-> (cnt_r == frame_timing_pkg::FP_START_CNT))
    else $error("Frame pulse started at wrong count");

  AST_FP_C4_ALIGN: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    ($fell(o_regenerated_frame_pulse_out_n) && !$past(realign) && !$past(i_sys_rst, 2))
    |-> $rose(o_derived_clock_4m_out))
    else $error("Frame pulse not aligned to 4 MHz clock");

  AST_CNT_RESET: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (boundary && !i_clock_delay_select) |=> (cnt_r == frame_timing_pkg::CNT_ZERO))
    else $error("Counter not reset after boundary");

  AST_C4_MID: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    ($fell(o_derived_clock_4m_out) && !o_regenerated_frame_pulse_out_n && !$past(realign))
    |-> (!$past(o_regenerated_frame_pulse_out_n, 2) && $past(o_regenerated_frame_pulse_out_n, 3)))
    else $error("4 MHz clock fall not centred in frame pulse");

  AST_CNT_WRAP: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (cnt_r == frame_timing_pkg::CNT_LAST) |=> (cnt_r == frame_timing_pkg::CNT_ZERO))
    else $error("Counter did not wrap after 2048 cycles");

  AST_CNT_RESET_DLY: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (boundary && i_clock_delay_select) ##1 i_clock_delay_select |=> (cnt_r == 11'h000))
    else $error("Counter not reset one cycle after boundary");

  AST_PEND_CLEAR: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (boundary && !fp_fall) |=> !pend_r)
    else $error("Frame pulse still armed after boundary");

  AST_DFP_AT_COUNT: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    ($past(cnt_r) == frame_timing_pkg::DFP_TOGGLE_CNT) |-> $changed(o_data_memory_frame_pulse))
    else $error("Data-memory pulse missed its toggle count");

  AST_DFP_N_SAME: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    $changed(o_data_memory_frame_pulse) |-> $changed(o_data_memory_frame_pulse_n))
    else $error("Data-memory pulse pair did not switch together");

  AST_FP_END: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_regenerated_frame_pulse_out_n) |-> (cnt_r == 11'h002))
    else $error("Frame pulse ended at wrong count");

  AST_FP_C4_ALIGN_END: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_regenerated_frame_pulse_out_n) |-> $rose(o_derived_clock_4m_out))
    else $error("Frame pulse end not aligned to 4 MHz clock");

  AST_C4_DECODE: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    o_derived_clock_4m_out == cnt_r[frame_timing_pkg::C4_PHASE_BIT])
    else $error("4 MHz clock not decoded from counter");

  AST_CNT_STEP: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (!$past(reset_req) && !$past(i_sys_rst))
    |-> (cnt_r == $past(cnt_r) + frame_timing_pkg::CNT_STEP))
    else $error("Counter did not advance by one");
endmodule

// file: testbench/frame_source.sv
`timescale 1ns/1ps
// Far side: sync clock locked to master clock, one frame pulse per 2048 cycles
module frame_source (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  output logic      o_sync_clock_4m,
  output logic      o_frame_pulse_n
);
  logic [10:0] phase_r;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase_r <= 11'h000;
    end else begin
      phase_r <= phase_r + 11'h001;
    end
  end
  assign o_sync_clock_4m = phase_r[1];
  // Falls on the same cycle the sync clock rises, two cycles clear of its fall
  assign o_frame_pulse_n = !(phase_r >= 11'h00a && phase_r <= 11'h00d);
endmodule

// file: testbench/test_frame_timing_generator.sv
`timescale 1ns/1ps
module test_frame_timing_generator;
  logic clk   = 1'b0;
  logic rst   = 1'b1;
  logic dly   = 1'b0;
  logic c4_p  = 1'b0;
  logic fi_p  = 1'b1;
  logic c4_in;
  logic fp_in_n;
  logic dfp;
  logic dfp_n;
  logic fp_n;
  logic c4;
  logic dfp_h [4096];
  logic fp_h  [4096];
  logic c4_h  [4096];
  int   n          = 0;
  int   nf         = 0;
  int   armed      = 0;
  int   cyc        = 0;
  int   fail_count = 0;
  int   checked    = 0;

  initial forever #2.5 clk = ~clk;

  frame_source src (.i_clk(clk), .i_sys_rst(rst), .o_sync_clock_4m(c4_in),
                    .o_frame_pulse_n(fp_in_n));
  frame_timing_generator uut (
    .i_clk                           (clk),
    .i_sys_rst                       (rst),
    .i_sync_clock_4m_in              (c4_in),
    .i_system_frame_pulse_in_n       (fp_in_n),
    .i_clock_delay_select            (dly),
    .o_data_memory_frame_pulse       (dfp),
    .o_data_memory_frame_pulse_n     (dfp_n),
    .o_regenerated_frame_pulse_out_n (fp_n),
    .o_derived_clock_4m_out          (c4)
  );

  task automatic chk(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // History of outputs and boundary finder, sampled mid-cycle
  always @(negedge clk) begin
    n++;
    dfp_h[n % 4096] = dfp;
    fp_h[n % 4096] = fp_n;
    c4_h[n % 4096] = c4;
    chk("dfp_n", ~dfp, dfp_n);
    if (rst) begin
      armed = 0;
    end else begin
      if (c4_p && !c4_in && armed != 0) begin
        nf = n;
        armed = 0;
      end
      if (fi_p && !fp_in_n) begin
        armed = 1;
      end
    end
    c4_p = c4_in;
    fi_p = fp_in_n;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic test_frame(input logic d);
    int b;
    int o;
    @(posedge clk) dly <= d;
    repeat (3 * 2048) @(posedge clk);
    b = nf - 2048;
    o = int'(d);
    chk("dfp early", dfp_h[(b + 63 + o) % 4096], dfp_h[(b + 64 + o) % 4096]);
    chk("dfp toggle", ~dfp_h[(b + 64 + o) % 4096], dfp_h[(b + 65 + o) % 4096]);
    chk("dfp frame", dfp_h[(b + 65 + o) % 4096], dfp_h[(b + 2047) % 4096]);
    for (int k = -1; k <= 4; k++) begin
      chk("fp_n", k < 0 || k > 3, fp_h[(b + k + o - 1) % 4096]);
      chk("c4", k == 0 || k == 1 || k == 4, c4_h[(b + k + o - 1) % 4096]);
    end
    $display("test frame delay %0d done", d);
  endtask

  task automatic test_reset;
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("dfp rst", frame_timing_pkg::DFP_RST, dfp);
    chk("fp_n rst", frame_timing_pkg::FP_N_RST, fp_n);
    chk("c4 rst", frame_timing_pkg::C4_RST, c4);
    @(posedge clk) rst <= 1'b0;
    $display("test reset done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    test_frame(1'b0);
    test_reset();
    test_frame(1'b1);
    give_verdict();
  end
endmodule
